// ---- dv/ebpm_assertions.sv ----
// concurrent checks on the ports of the bus control pin multiplexer
`timescale 1ns/1ps
module ebpm_checker (
  input wire SYS_CLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire BUS_IDLE,
  input wire SLEEP_MODE,
  input wire STOP_MODE,
  input wire CHIP_SELECT_3_N,
  input wire READ_STROBE_N,
  input wire READY_INPUT,
  input wire BUS_RELEASED,
  input wire PIN_BUS_RELEASE_REQUEST_I,
  input wire PIN_CHIP_SELECT_3_O,
  input wire PIN_CHIP_SELECT_3_OE,
  input wire PIN_BUS_GRANT_ACK_O,
  input wire PIN_READ_STROBE_O,
  input wire PIN_READ_STROBE_OE,
  input wire PIN_SYSTEM_CLOCK_OUT_O,
  input wire PIN_MEMORY_CLOCK_OUT_O
);
  reg [8:0] fe_r;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // shadow of the enables, so checks need no look inside
  always @(posedge SYS_CLK)
  begin
    if (RST)
      fe_r <= 9'h000;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00)
      fe_r <= PWDATA[8:0];
  end
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_unmapped_error: assert property (PSEL && PENABLE && PREADY && PADDR > 8'h10 |-> PSLVERR)
    else $error("unmapped access without error");
  a_cs3_follows: assert property (
    fe_r[0] && !BUS_RELEASED ##1 !BUS_RELEASED |->
    PIN_CHIP_SELECT_3_OE && PIN_CHIP_SELECT_3_O == $past(CHIP_SELECT_3_N))
    else $error("chip select not on pin");
  a_ready_default: assert property (!fe_r[1] |=> READY_INPUT)
    else $error("ready low while disabled");
  a_grant_level: assert property (
    fe_r[2] && $past(fe_r[2]) |-> PIN_BUS_GRANT_ACK_O == !BUS_RELEASED)
    else $error("grant level wrong");
  a_req_ignored: assert property (!fe_r[3] && !BUS_RELEASED |=> !BUS_RELEASED)
    else $error("release while request disabled");
  a_req_taken: assert property (
    (fe_r[3] && BUS_IDLE && PIN_BUS_RELEASE_REQUEST_I) [*5] |-> BUS_RELEASED)
    else $error("request not honoured");
  a_release_ends: assert property ((!PIN_BUS_RELEASE_REQUEST_I) [*5] |-> !BUS_RELEASED)
    else $error("bus kept released");
  a_read_strobe: assert property (
    fe_r[8] && !BUS_RELEASED ##1 !BUS_RELEASED |->
    PIN_READ_STROBE_OE && PIN_READ_STROBE_O == $past(READ_STROBE_N))
    else $error("read strobe not on pin");
  a_system_clock_out_stop: assert property ((fe_r[5] && STOP_MODE) [*5] |-> !PIN_SYSTEM_CLOCK_OUT_O)
    else $error("system clock runs in stop");
  a_memclk_stop: assert property (
    (fe_r[6] && (SLEEP_MODE || STOP_MODE)) [*5] |-> !PIN_MEMORY_CLOCK_OUT_O)
    else $error("memory clock runs in low power");
endmodule
bind ebpm_pin_mux ebpm_checker u_chk (.*);

// ---- dv/ebpm_far_side.sv ----
// far side: bus master on the release request, memory on ready
`timescale 1ns/1ps
module ebpm_far_side (
  input wire [9:0] oe,
  input wire [9:0] o,
  input wire ext_on,
  input wire req,
  input wire rdy,
  output wire [9:0] lvl,
  output wire clash
);
  wire [9:0] fe;
  wire [9:0] fv;
  // master asks release by a high level; memory drives ready on pin 1
  assign fe = {6'h00, ext_on, 1'h0, ext_on, 1'h0};
  assign fv = {6'h00, req, 1'h0, rdy, 1'h0};
  // undriven lines sit at the pull-up level, except the request line:
  // its pull-down keeps an absent master from asking for the bus
  assign lvl = (oe & o) | (~oe & fe & fv) | (~oe & ~fe & 10'h3F7);
  // two drivers on one line is a board fault
  assign clash = |(oe & fe);
endmodule

// ---- dv/ebpm_pin_mux_test.sv ----
// self-checking bench for the bus control pin multiplexer
`timescale 1ns/1ps
module ebpm_pin_mux_test;
  typedef struct packed {
    logic [8:0] fe;
    logic [9:0] out, dir;
    logic [4:0] fv;
    logic [9:0] oe, o;
  } ebpm_row_t;
  ebpm_row_t rows [0:4] = '{{9'h000, 10'h155, 10'h3FF, 5'h00, 10'h3FF, 10'h155},
    {9'h000, 10'h2AA, 10'h000, 5'h1F, 10'h000, 10'h000},
    {9'h18D, 10'h000, 10'h3FF, 5'h1F, 10'h3F7, 10'h235},
    {9'h112, 10'h3FF, 10'h3FF, 5'h00, 10'h3FD, 10'h38D},
    {9'h010, 10'h000, 10'h040, 5'h1F, 10'h040, 10'h000}};
  logic SYS_CLK = 1'h0, RST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, er;
  logic EXT_BUS_CLK = 1'h0, SLEEP_MODE = 1'h0, STOP_MODE = 1'h0, BUS_IDLE = 1'h1;
  logic req = 1'h0, rdy = 1'h1, ext_on = 1'h0, p7, p8;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, rd;
  logic [4:0] fv = 5'h00;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, READY_INPUT, BUS_RELEASED, clash;
  wire [3:0] CAPTURE_IN;
  wire [9:0] pi, po, poe;
  integer fails = 0, checks = 0, cyc = 0, i, t7, t8, e7, e8;
  ebpm_pin_mux uut (.SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .EXT_BUS_CLK, .SLEEP_MODE, .STOP_MODE, .BUS_IDLE,
    .CHIP_SELECT_3_N(fv[0]), .READ_STROBE_N(fv[1]), .WRITE_STROBE_LOW_N(fv[2]),
    .WRITE_STROBE_UPPER_N(fv[3]), .ADDRESS_STROBE_N(fv[4]), .READY_INPUT, .BUS_RELEASED,
    .CAPTURE_IN, .PIN_CHIP_SELECT_3_I(pi[0]), .PIN_CHIP_SELECT_3_O(po[0]),
    .PIN_CHIP_SELECT_3_OE(poe[0]), .PIN_READY_INPUT_I(pi[1]), .PIN_READY_INPUT_O(po[1]),
    .PIN_READY_INPUT_OE(poe[1]), .PIN_BUS_GRANT_ACK_I(pi[2]), .PIN_BUS_GRANT_ACK_O(po[2]),
    .PIN_BUS_GRANT_ACK_OE(poe[2]), .PIN_BUS_RELEASE_REQUEST_I(pi[3]),
    .PIN_BUS_RELEASE_REQUEST_O(po[3]), .PIN_BUS_RELEASE_REQUEST_OE(poe[3]),
    .PIN_READ_STROBE_I(pi[4]), .PIN_READ_STROBE_O(po[4]), .PIN_READ_STROBE_OE(poe[4]),
    .PIN_WRITE_STROBE_LOW_I(pi[5]), .PIN_WRITE_STROBE_LOW_O(po[5]),
    .PIN_WRITE_STROBE_LOW_OE(poe[5]), .PIN_WRITE_STROBE_UPPER_I(pi[6]),
    .PIN_WRITE_STROBE_UPPER_O(po[6]), .PIN_WRITE_STROBE_UPPER_OE(poe[6]),
    .PIN_SYSTEM_CLOCK_OUT_I(pi[7]), .PIN_SYSTEM_CLOCK_OUT_O(po[7]),
    .PIN_SYSTEM_CLOCK_OUT_OE(poe[7]), .PIN_MEMORY_CLOCK_OUT_I(pi[8]),
    .PIN_MEMORY_CLOCK_OUT_O(po[8]), .PIN_MEMORY_CLOCK_OUT_OE(poe[8]),
    .PIN_ADDRESS_STROBE_I(pi[9]), .PIN_ADDRESS_STROBE_O(po[9]), .PIN_ADDRESS_STROBE_OE(poe[9]));
  ebpm_far_side far (.oe(poe), .o(po), .ext_on(ext_on), .req(req), .rdy(rdy), .lvl(pi),
    .clash(clash));
  initial
  begin
    forever #25 SYS_CLK = ~SYS_CLK;
  end
  // odd start keeps the bus clock out of phase with the system clock
  initial
  begin
    #37;
    forever #200 EXT_BUS_CLK = ~EXT_BUS_CLK;
  end
  task test_done;
  begin
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  always @(posedge SYS_CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      fails = fails + 1;
      test_done;
    end
  end
  task chk(input logic [63:0] g, input logic [63:0] e);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge SYS_CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'h1;
    @(posedge SYS_CLK);
    while (PREADY !== 1'h1)
      @(posedge SYS_CLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  end
  endtask
  // settle on the falling edge so registered outputs have landed
  task w(input integer n);
  begin
    repeat (n) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
  end
  endtask
  task tog;
  begin
    t7 = 0;
    t8 = 0;
    e7 = 0;
    e8 = 0;
    repeat (4) @(posedge SYS_CLK);
    p7 = po[7];
    p8 = po[8];
    // 48 samples span exactly six bus clock periods, so six rising edges
    repeat (48)
    begin
      @(posedge SYS_CLK);
      t7 = t7 + po[7];
      t8 = t8 + po[8];
      e7 = e7 + (po[7] & ~p7);
      e8 = e8 + (po[8] & ~p8);
      p7 = po[7];
      p8 = po[8];
    end
  end
  endtask
  initial
  begin
    repeat (5) @(posedge SYS_CLK);
    RST <= 1'h0;
    w(1);
    chk({poe, READY_INPUT, BUS_RELEASED}, 12'h002);
    for (i = 0; i < 5; i = i + 1)
    begin
      apb(1'h0, {i[5:0], 2'h0}, 32'h0);
      chk({er, rd}, i == 3 ? 33'h0000003F7 : 33'h0);
    end
    apb(1'h1, 8'h14, 32'hFFFFFFFF);
    chk(er, 1'h1);
    apb(1'h1, 8'h04, 32'hFFFFFFFF);
    apb(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h3FF);
    for (i = 0; i < 5; i = i + 1)
    begin
      apb(1'h1, 8'h00, rows[i].fe);
      apb(1'h1, 8'h04, rows[i].out);
      apb(1'h1, 8'h08, rows[i].dir);
      @(posedge SYS_CLK);
      fv <= rows[i].fv;
      w(3);
      chk(poe, rows[i].oe);
      chk(po & poe, rows[i].o);
    end
    // master on; direction of pins 1 and 3 stays input
    @(posedge SYS_CLK);
    ext_on <= 1'h1;
    rdy <= 1'h0;
    req <= 1'h1;
    BUS_IDLE <= 1'h0;
    apb(1'h1, 8'h00, 32'h106);
    w(6);
    chk({BUS_RELEASED, READY_INPUT}, 2'h0);
    apb(1'h1, 8'h00, 32'h10C);
    w(6);
    chk({BUS_RELEASED, poe[4]}, 2'h1);
    @(posedge SYS_CLK);
    BUS_IDLE <= 1'h1;
    w(6);
    chk({BUS_RELEASED, READY_INPUT, po[2], poe[4], clash, CAPTURE_IN}, 9'h184);
    apb(1'h0, 8'h10, 32'h0);
    chk(rd, 32'h3);
    @(posedge SYS_CLK);
    req <= 1'h0;
    w(8);
    chk({BUS_RELEASED, po[2], poe[4], CAPTURE_IN}, 7'h32);
    apb(1'h1, 8'h00, 32'h160);
    tog;
    chk({t7 > 12 && t7 < 36, t8 > 12 && t8 < 36, e7 == 6, e8 == 6}, 4'hF);
    @(posedge SYS_CLK);
    SLEEP_MODE <= 1'h1;
    tog;
    chk({t7 > 12 && t7 < 36, t8 == 0, e7 == 6}, 3'h7);
    @(posedge SYS_CLK);
    STOP_MODE <= 1'h1;
    tog;
    chk(t7 + t8, 32'h0);
    // reset in mid-run brings pins and registers back to idle
    @(posedge SYS_CLK);
    RST <= 1'h1;
    w(2);
    chk({poe, po, READY_INPUT, BUS_RELEASED, CAPTURE_IN}, 26'h0000020);
    @(posedge SYS_CLK);
    RST <= 1'h0;
    apb(1'h0, 8'h00, 32'h0);
    chk({er, rd}, 33'h0);
    test_done;
  end
endmodule

// ---- verilog/ebpm_map.vh ----
// register map, field positions and reset values of the bus control pin multiplexer
`ifndef EBPM_MAP_VH
`define EBPM_MAP_VH

// register byte offsets
`define EBPM_FUNC_EN_OFS 8'h00
`define EBPM_PORT_OUT_OFS 8'h04
`define EBPM_PORT_DIR_OFS 8'h08
`define EBPM_PIN_LEVEL_OFS 8'h0C
`define EBPM_STATUS_OFS 8'h10

// function enable register fields
`define EBPM_FE_CHIP_SELECT_3 0
`define EBPM_FE_READY_INPUT 1
`define EBPM_FE_BUS_GRANT_ACK 2
`define EBPM_FE_BUS_RELEASE_REQ 3
`define EBPM_FE_WRITE_STROBE_UPPER 4
`define EBPM_FE_SYSTEM_CLOCK_OUT 5
`define EBPM_FE_MEMORY_CLOCK_OUT 6
`define EBPM_FE_ADDRESS_STROBE 7
`define EBPM_FE_EXT_BUS_MODE 8
`define EBPM_FE_WIDTH 9
`define EBPM_FUNC_EN_RST 9'h000

// pin index in port out, port dir and pin level registers
`define EBPM_PIN_PORT_A_BIT3 0
`define EBPM_PIN_PORT8_BIT0 1
`define EBPM_PIN_PORT8_BIT1 2
`define EBPM_PIN_PORT8_BIT2 3
`define EBPM_PIN_PORT8_BIT3 4
`define EBPM_PIN_PORT8_BIT4 5
`define EBPM_PIN_PORT8_BIT5 6
`define EBPM_PIN_PORT9_BIT0 7
`define EBPM_PIN_PORT9_BIT2 8
`define EBPM_PIN_PORT9_BIT4 9
`define EBPM_PIN_COUNT 10
`define EBPM_PORT_OUT_RST 10'h000
`define EBPM_PORT_DIR_RST 10'h000

// status register fields
`define EBPM_ST_RELEASED 0
`define EBPM_ST_RELEASE_REQ 1
`define EBPM_ST_SLEEP 2
`define EBPM_ST_STOP 3

`endif

// ---- verilog/ebpm_pin_mux.v ----
// external bus control pin multiplexer with apb register slave
// Behaviour
// - shared pin drives chip_select_3 when enabled and bus not released; port_a_bit3 when disabled.
// - ready_input sampled only while enabled; otherwise pin is port8_bit0.
// - bus_grant_ack driven low while bus released, when enabled; else port8_bit1.
// - high bus_release_request asks release; honoured only when enabled; else port8_bit2.
// - read_strobe driven in external bus mode while bus not released; port8_bit3 in single-chip mode.
// - write_strobe_low driven in external bus mode while bus not released; port8_bit4 in single-chip mode.
// - write_strobe_upper needs its enable and external bus mode; else port8_bit5.
// - system_clock_out follows external bus clock, stops only in stop mode; else port9_bit0.
// - memory_clock_out follows bus clock, stops in sleep and stop; else port9_bit2.
// - address_strobe driven when enabled and bus not released; pin is port9_bit4 when disabled.
`timescale 1ns/1ps
`include "ebpm_map.vh"

module ebpm_pin_mux #(
  parameter NPIN = `EBPM_PIN_COUNT
) (
  input wire SYS_CLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire EXT_BUS_CLK,
  input wire SLEEP_MODE,
  input wire STOP_MODE,
  input wire BUS_IDLE,
  input wire CHIP_SELECT_3_N,
  input wire READ_STROBE_N,
  input wire WRITE_STROBE_LOW_N,
  input wire WRITE_STROBE_UPPER_N,
  input wire ADDRESS_STROBE_N,
  output wire READY_INPUT,
  output wire BUS_RELEASED,
  output wire [3:0] CAPTURE_IN,
  input wire PIN_CHIP_SELECT_3_I,
  output wire PIN_CHIP_SELECT_3_O,
  output wire PIN_CHIP_SELECT_3_OE,
  input wire PIN_READY_INPUT_I,
  output wire PIN_READY_INPUT_O,
  output wire PIN_READY_INPUT_OE,
  input wire PIN_BUS_GRANT_ACK_I,
  output wire PIN_BUS_GRANT_ACK_O,
  output wire PIN_BUS_GRANT_ACK_OE,
  input wire PIN_BUS_RELEASE_REQUEST_I,
  output wire PIN_BUS_RELEASE_REQUEST_O,
  output wire PIN_BUS_RELEASE_REQUEST_OE,
  input wire PIN_READ_STROBE_I,
  output wire PIN_READ_STROBE_O,
  output wire PIN_READ_STROBE_OE,
  input wire PIN_WRITE_STROBE_LOW_I,
  output wire PIN_WRITE_STROBE_LOW_O,
  output wire PIN_WRITE_STROBE_LOW_OE,
  input wire PIN_WRITE_STROBE_UPPER_I,
  output wire PIN_WRITE_STROBE_UPPER_O,
  output wire PIN_WRITE_STROBE_UPPER_OE,
  input wire PIN_SYSTEM_CLOCK_OUT_I,
  output wire PIN_SYSTEM_CLOCK_OUT_O,
  output wire PIN_SYSTEM_CLOCK_OUT_OE,
  input wire PIN_MEMORY_CLOCK_OUT_I,
  output wire PIN_MEMORY_CLOCK_OUT_O,
  output wire PIN_MEMORY_CLOCK_OUT_OE,
  input wire PIN_ADDRESS_STROBE_I,
  output wire PIN_ADDRESS_STROBE_O,
  output wire PIN_ADDRESS_STROBE_OE
);

  // register state
  reg [`EBPM_FE_WIDTH-1:0] func_en_r;
  reg [NPIN-1:0] port_out_r;
  reg [NPIN-1:0] port_dir_r;
  reg [31:0] prdata_r;
  reg pready_r;
  reg pslverr_r;

  // synchronisers
  reg [NPIN-1:0] pin_meta_r;
  reg [NPIN-1:0] pin_sync_r;
  reg clk_meta_r;
  reg clk_sync_r;

  // pin and side outputs
  reg [NPIN-1:0] pin_o_r;
  reg [NPIN-1:0] pin_oe_r;
  reg [NPIN-1:0] pin_o_nxt;
  reg [NPIN-1:0] pin_oe_nxt;
  reg released_r;
  reg released_nxt;
  reg ready_r;
  reg [3:0] capture_r;

  wire [NPIN-1:0] pin_i;
  wire setup_ph;
  wire access_ph;
  wire wr_en;
  wire ext_mode;
  wire release_req;
  wire sys_clk_run;
  wire mem_clk_run;

  // one-hot selects returned by reg_hit
  localparam hit_none = 5'h00;
  localparam hit_func_en = 5'h01;
  localparam hit_port_out = 5'h02;
  localparam hit_port_dir = 5'h04;
  localparam hit_pin_level = 5'h08;
  localparam hit_status = 5'h10;

  // pick port driver or function driver for one pin
  function [1:0] pin_mux;
    input fn_sel;
    input fn_oe;
    input fn_val;
    input prt_oe;
    input prt_val;
    begin
      if (fn_sel)
        pin_mux = {fn_oe, fn_val};
      else
        pin_mux = {prt_oe, prt_val};
    end
  endfunction

  // register select decode, shared by read and write paths
  function [4:0] reg_hit;
    input [7:0] addr;
    begin
      reg_hit = hit_none;
      case (addr)
        `EBPM_FUNC_EN_OFS: reg_hit = hit_func_en;
        `EBPM_PORT_OUT_OFS: reg_hit = hit_port_out;
        `EBPM_PORT_DIR_OFS: reg_hit = hit_port_dir;
        `EBPM_PIN_LEVEL_OFS: reg_hit = hit_pin_level;
        `EBPM_STATUS_OFS: reg_hit = hit_status;
        default: reg_hit = hit_none;
      endcase
    end
  endfunction

  assign pin_i = {PIN_ADDRESS_STROBE_I, PIN_MEMORY_CLOCK_OUT_I, PIN_SYSTEM_CLOCK_OUT_I,
                  PIN_WRITE_STROBE_UPPER_I, PIN_WRITE_STROBE_LOW_I, PIN_READ_STROBE_I,
                  PIN_BUS_RELEASE_REQUEST_I, PIN_BUS_GRANT_ACK_I, PIN_READY_INPUT_I,
                  PIN_CHIP_SELECT_3_I};

  // pins and the bus clock come from outside, two flops before use
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      pin_meta_r <= {NPIN{1'b0}};
      pin_sync_r <= {NPIN{1'b0}};
      clk_meta_r <= 1'b0;
      clk_sync_r <= 1'b0;
    end
    else
    begin
      pin_meta_r <= pin_i;
      pin_sync_r <= pin_meta_r;
      clk_meta_r <= EXT_BUS_CLK;
      clk_sync_r <= clk_meta_r;
    end
  end

  // apb: zero wait states, pready raised from the setup cycle
  assign setup_ph = PSEL & ~PENABLE;
  assign access_ph = PSEL & PENABLE & pready_r;
  assign wr_en = access_ph & PWRITE;

  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= setup_ph;
      pslverr_r <= setup_ph & (reg_hit(PADDR) == hit_none);
      prdata_r <= 32'h00000000;
      if (setup_ph & ~PWRITE)
      begin
        case (reg_hit(PADDR))
          hit_func_en: prdata_r <= {{(32-`EBPM_FE_WIDTH){1'b0}}, func_en_r};
          hit_port_out: prdata_r <= {{(32-NPIN){1'b0}}, port_out_r};
          hit_port_dir: prdata_r <= {{(32-NPIN){1'b0}}, port_dir_r};
          hit_pin_level: prdata_r <= {{(32-NPIN){1'b0}}, pin_sync_r};
          hit_status: prdata_r <= {28'h0000000, STOP_MODE, SLEEP_MODE, release_req, released_r};
          default: prdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  // writable registers; pin level and status are read-only
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      func_en_r <= `EBPM_FUNC_EN_RST;
      port_out_r <= `EBPM_PORT_OUT_RST;
      port_dir_r <= `EBPM_PORT_DIR_RST;
    end
    else if (wr_en)
    begin
      // pin level, status and unmapped offsets keep their value
      case (reg_hit(PADDR))
        hit_func_en: func_en_r <= PWDATA[`EBPM_FE_WIDTH-1:0];
        hit_port_out: port_out_r <= PWDATA[NPIN-1:0];
        hit_port_dir: port_dir_r <= PWDATA[NPIN-1:0];
        default: func_en_r <= func_en_r;
      endcase
    end
  end

  assign ext_mode = func_en_r[`EBPM_FE_EXT_BUS_MODE];
  assign release_req = func_en_r[`EBPM_FE_BUS_RELEASE_REQ] & pin_sync_r[`EBPM_PIN_PORT8_BIT2];
  assign sys_clk_run = clk_sync_r & ~STOP_MODE;
  assign mem_clk_run = clk_sync_r & ~STOP_MODE & ~SLEEP_MODE;

  // release waits for an idle bus so no cycle is cut short
  always @*
  begin
    released_nxt = released_r;
    // grant once the bus is idle
    if (release_req & BUS_IDLE)
      released_nxt = 1'b1;
    if (~release_req)
      released_nxt = 1'b0;
  end

  always @*
  begin
    pin_o_nxt = {NPIN{1'b0}};
    pin_oe_nxt = {NPIN{1'b0}};
    {pin_oe_nxt[0], pin_o_nxt[0]} = pin_mux(func_en_r[`EBPM_FE_CHIP_SELECT_3], ~released_nxt,
      CHIP_SELECT_3_N, port_dir_r[0], port_out_r[0]);
    // ready input keeps the driver off
    {pin_oe_nxt[1], pin_o_nxt[1]} = pin_mux(func_en_r[`EBPM_FE_READY_INPUT], 1'b0, 1'b0,
      port_dir_r[1], port_out_r[1]);
    {pin_oe_nxt[2], pin_o_nxt[2]} = pin_mux(func_en_r[`EBPM_FE_BUS_GRANT_ACK], 1'b1,
      ~released_nxt, port_dir_r[2], port_out_r[2]);
    {pin_oe_nxt[3], pin_o_nxt[3]} = pin_mux(func_en_r[`EBPM_FE_BUS_RELEASE_REQ], 1'b0, 1'b0,
      port_dir_r[3], port_out_r[3]);
    // read strobe in external bus mode
    {pin_oe_nxt[4], pin_o_nxt[4]} = pin_mux(ext_mode, ~released_nxt, READ_STROBE_N,
      port_dir_r[4], port_out_r[4]);
    // low write strobe in external bus mode
    {pin_oe_nxt[5], pin_o_nxt[5]} = pin_mux(ext_mode, ~released_nxt, WRITE_STROBE_LOW_N,
      port_dir_r[5], port_out_r[5]);
    // upper strobe needs enable and mode
    {pin_oe_nxt[6], pin_o_nxt[6]} = pin_mux(ext_mode & func_en_r[`EBPM_FE_WRITE_STROBE_UPPER],
      ~released_nxt, WRITE_STROBE_UPPER_N, port_dir_r[6], port_out_r[6]);
    {pin_oe_nxt[7], pin_o_nxt[7]} = pin_mux(func_en_r[`EBPM_FE_SYSTEM_CLOCK_OUT], 1'b1,
      sys_clk_run, port_dir_r[7], port_out_r[7]);
    {pin_oe_nxt[8], pin_o_nxt[8]} = pin_mux(func_en_r[`EBPM_FE_MEMORY_CLOCK_OUT], 1'b1,
      mem_clk_run, port_dir_r[8], port_out_r[8]);
    {pin_oe_nxt[9], pin_o_nxt[9]} = pin_mux(func_en_r[`EBPM_FE_ADDRESS_STROBE], ~released_nxt,
      ADDRESS_STROBE_N, port_dir_r[9], port_out_r[9]);
  end

  // every pin and side output leaves from a flop
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      pin_o_r <= {NPIN{1'b0}};
      pin_oe_r <= {NPIN{1'b0}};
      released_r <= 1'b0;
    end
    else
    begin
      pin_o_r <= pin_o_nxt;
      pin_oe_r <= pin_oe_nxt;
      released_r <= released_nxt;
    end
  end

  // side inputs for the bus controller and the capture unit
  // ready idles high so a disabled input never stretches a bus cycle
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ready_r <= 1'b1;
      capture_r <= 4'h0;
    end
    else
    begin
      // ready only while enabled, else no wait
      ready_r <= ~func_en_r[`EBPM_FE_READY_INPUT] | pin_sync_r[`EBPM_PIN_PORT8_BIT0];
      // capture sees the pin; a driven port would override it
      capture_r <= {pin_sync_r[`EBPM_PIN_PORT8_BIT5], pin_sync_r[`EBPM_PIN_PORT8_BIT2],
                    pin_sync_r[`EBPM_PIN_PORT8_BIT1], pin_sync_r[`EBPM_PIN_PORT8_BIT0]};
    end
  end

  // clock outputs are the bus clock resampled, so jitter is one sys_clk period
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign READY_INPUT = ready_r;
  assign BUS_RELEASED = released_r;
  assign CAPTURE_IN = capture_r;
  assign PIN_CHIP_SELECT_3_O = pin_o_r[0];
  assign PIN_CHIP_SELECT_3_OE = pin_oe_r[0];
  assign PIN_READY_INPUT_O = pin_o_r[1];
  assign PIN_READY_INPUT_OE = pin_oe_r[1];
  assign PIN_BUS_GRANT_ACK_O = pin_o_r[2];
  assign PIN_BUS_GRANT_ACK_OE = pin_oe_r[2];
  assign PIN_BUS_RELEASE_REQUEST_O = pin_o_r[3];
  assign PIN_BUS_RELEASE_REQUEST_OE = pin_oe_r[3];
  assign PIN_READ_STROBE_O = pin_o_r[4];
  assign PIN_READ_STROBE_OE = pin_oe_r[4];
  assign PIN_WRITE_STROBE_LOW_O = pin_o_r[5];
  assign PIN_WRITE_STROBE_LOW_OE = pin_oe_r[5];
  assign PIN_WRITE_STROBE_UPPER_O = pin_o_r[6];
  assign PIN_WRITE_STROBE_UPPER_OE = pin_oe_r[6];
  assign PIN_SYSTEM_CLOCK_OUT_O = pin_o_r[7];
  assign PIN_SYSTEM_CLOCK_OUT_OE = pin_oe_r[7];
  assign PIN_MEMORY_CLOCK_OUT_O = pin_o_r[8];
  assign PIN_MEMORY_CLOCK_OUT_OE = pin_oe_r[8];
  assign PIN_ADDRESS_STROBE_O = pin_o_r[9];
  assign PIN_ADDRESS_STROBE_OE = pin_oe_r[9];

endmodule
